/* core/pcb_pkg.sv */
// Package of constants and types for the path command buffer sequencer
package pcb_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int unsigned PCB_DEPTH = 4096;
   localparam int unsigned PCB_WORD_W = 16;
   localparam int unsigned PCB_AW = 12;
   localparam int unsigned PCB_SEG_W = 16;
   // ----------------------------------------
   // Result codes and status bits
   // ----------------------------------------
   localparam logic [1:0] PCB_RES_OK = 2'h0;
   localparam logic [1:0] PCB_RES_WRONG = 2'h1;
   localparam logic [1:0] PCB_RES_FULL = 2'h2;
   localparam int unsigned PCB_STS_DONE_BIT = 0;
   localparam int unsigned PCB_STS_CLOSED_BIT = 1;
   localparam int unsigned PCB_STS_ERR_BIT = 3;
   localparam int unsigned PCB_STS_SINGLE_BIT = 7;
   localparam logic [7:0] PCB_STS_RESET = 8'h81;

   typedef enum logic [3:0] {
      PCB_CMD_OPEN_CLEAR_LIST,
      PCB_CMD_START_POINT,
      PCB_CMD_PARAM,
      PCB_CMD_PATH,
      PCB_CMD_CLOSE_LIST,
      PCB_CMD_REOPEN_LIST,
      PCB_CMD_START_BUFFERED_MOTION,
      PCB_CMD_SMOOTH_STOP_MOTION,
      PCB_CMD_ABRUPT_STOP_MOTION
   } pcb_cmd_t;

   typedef enum logic [1:0] {
      PCB_EX_BUFFER,
      PCB_EX_SINGLE,
      PCB_EX_APPROACH,
      PCB_EX_SMOOTH_STOP
   } pcb_exec_kind_t;

   typedef struct packed {
      pcb_cmd_t cmd;
      logic [PCB_WORD_W-1:0] word;
   } pcb_req_t;

   typedef struct packed {
      pcb_exec_kind_t kind;
      logic [PCB_WORD_W-1:0] word;
   } pcb_exec_t;
endpackage

/* core/pcb_mem.sv */
// Command store memory with registered read data
`timescale 1ns/100ps
module pcb_mem
   import pcb_pkg::*;
#(
   parameter int unsigned AW = PCB_AW,
   parameter int unsigned DW = PCB_WORD_W
) (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [DW-1:0] wr_data_i,
   input wire logic rd_en_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [DW-1:0] rd_data_o
);
   logic [DW-1:0] mem_ff [0:(1<<AW)-1];

   // No reset on the array so it maps onto block memory
   always_ff @(posedge clk_i) begin
      if (ce_i && wr_en_i) begin
         mem_ff[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i && rd_en_i) begin
         rd_data_o <= mem_ff[rd_addr_i];
      end
   end
endmodule

/* core/pcb_sequencer.sv */
// Path command buffer sequencer: list state, circular store and execution feed
// Operation
// R1: Open-and-clear enters input state and discards all unexecuted buffered commands.
// R2: Host opens the list before any other buffer operation after power-up.
// R3: Host pushes one start-point command right after open-and-clear.
// R4: Start point executes first as a straight accel-decel move, then entries in order.
// R5: Start-point velocity and acceleration apply to later entries until replaced.
// R6: Close-list is accepted only while open and ends the input state.
// R7: Reopen returns a closed, once-opened list to input state, repeatable.
// R8: Host closes the list after the last path command.
// R9: Store is a 4096 by 16 bit circular buffer with wrapping pointers.
// R10: When full, path and parameter commands are refused with full status.
// R11: Consumed entries free space for new commands.
// R12: Start-motion executes buffered entries one by one in push order.
// R13: Host starts motion only after opening and pushing a start point.
// R14: While open after start, newly pushed entries keep being executed.
// R15: Smooth stop decelerates, abrupt stop halts immediately.
// R16: Either stop also closes the list like close-list.
// R17: After a stop, path commands execute at once as single segments.
// R18: Restart with entries left first returns to breakpoint, then resumes.
// R19: Stop during start-point or breakpoint approach flags a motion error.
// R20: Path command during single-segment motion is refused with code 1.
// R21: Closed-list status bit 1 sets on close or either stop.
// R22: Open-and-clear zeroes the executed-segment counter.
// R23: Pointers give full and empty; open and empty shows waiting.
`timescale 1ns/100ps
module pcb_sequencer
   import pcb_pkg::*;
#(
   parameter int unsigned AW = PCB_AW
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic req_valid_i,
   input wire pcb_req_t req_i,
   output logic res_valid_o,
   output logic [1:0] res_code_o,
   output logic exec_valid_o,
   output pcb_exec_t exec_o,
   input wire logic exec_ready_i,
   input wire logic motion_done_i,
   output logic [7:0] status_o,
   output logic [PCB_SEG_W-1:0] seg_num_o,
   output logic waiting_o,
   output logic full_o
);
   // ----------------------------------------
   // List state
   // ----------------------------------------
   typedef enum logic [1:0] {
      PCB_L_IDLE,
      PCB_L_OPEN,
      PCB_L_CLOSED
   } pcb_list_t;

   pcb_list_t list_ff;
   logic running_ff;
   logic approach_ff;
   logic need_approach_ff;
   logic single_busy_ff;
   logic [AW:0] wr_ptr_ff;
   logic [AW:0] rd_ptr_ff;
   logic rd_pend_ff;
   logic rd_first_ff;

   wire logic is_open = (list_ff == PCB_L_OPEN);
   wire logic empty = (wr_ptr_ff == rd_ptr_ff);
   wire logic full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                     (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]); // [R23]
   wire logic cmd_v = req_valid_i && ce_i;
   wire logic is_open_clr = cmd_v && req_i.cmd == PCB_CMD_OPEN_CLEAR_LIST;
   wire logic is_stop = cmd_v && (req_i.cmd == PCB_CMD_SMOOTH_STOP_MOTION ||
                                  req_i.cmd == PCB_CMD_ABRUPT_STOP_MOTION);
   wire logic is_push_cmd = req_i.cmd == PCB_CMD_START_POINT || req_i.cmd == PCB_CMD_PARAM ||
                            req_i.cmd == PCB_CMD_PATH;
   wire logic push_ok = cmd_v && is_open && is_push_cmd && !full; // [R10]
   wire logic single_go = cmd_v && !is_open && req_i.cmd == PCB_CMD_PATH && !single_busy_ff;

   // Skid buffer handshake towards the motion engine
   logic buf_in_ready;
   logic buf_in_valid;
   pcb_exec_t buf_in;
   logic [PCB_WORD_W-1:0] rd_data;

   // ----------------------------------------
   // Command result
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         res_valid_o <= 1'b0;
         res_code_o <= PCB_RES_OK;
      end else if (ce_i) begin
         res_valid_o <= req_valid_i;
         res_code_o <= PCB_RES_OK;
         if (req_valid_i) begin
            unique case (req_i.cmd)
               PCB_CMD_START_POINT, PCB_CMD_PARAM: begin
                  if (is_open && full) begin
                     res_code_o <= PCB_RES_FULL; // [R10]
                  end else if (!is_open) begin
                     res_code_o <= PCB_RES_WRONG;
                  end
               end
               PCB_CMD_PATH: begin
                  if (is_open && full) begin
                     res_code_o <= PCB_RES_FULL; // [R10]
                  end else if (!is_open && (single_busy_ff || !buf_in_ready)) begin
                     res_code_o <= PCB_RES_WRONG; // [R20]
                  end
               end
               PCB_CMD_CLOSE_LIST: begin
                  if (!is_open) begin
                     res_code_o <= PCB_RES_WRONG; // [R6]
                  end
               end
               PCB_CMD_REOPEN_LIST: begin
                  if (list_ff != PCB_L_CLOSED) begin
                     res_code_o <= PCB_RES_WRONG; // [R7]
                  end
               end
               PCB_CMD_START_BUFFERED_MOTION: begin
                  if (list_ff == PCB_L_IDLE || running_ff) begin
                     res_code_o <= PCB_RES_WRONG;
                  end
               end
               PCB_CMD_SMOOTH_STOP_MOTION, PCB_CMD_ABRUPT_STOP_MOTION: begin
                  if (approach_ff) begin
                     res_code_o <= PCB_RES_WRONG; // [R19]
                  end
               end
               default: begin
                  res_code_o <= PCB_RES_OK;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // List open/closed state
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         list_ff <= PCB_L_IDLE;
      end else if (cmd_v) begin
         if (req_i.cmd == PCB_CMD_OPEN_CLEAR_LIST) begin
            list_ff <= PCB_L_OPEN; // [R1]
         end else if (req_i.cmd == PCB_CMD_CLOSE_LIST && is_open) begin
            list_ff <= PCB_L_CLOSED; // [R6]
         end else if (req_i.cmd == PCB_CMD_REOPEN_LIST && list_ff == PCB_L_CLOSED) begin
            list_ff <= PCB_L_OPEN; // [R7]
         end else if (is_stop && is_open) begin
            list_ff <= PCB_L_CLOSED; // [R16]
         end
      end
   end

   // ----------------------------------------
   // Circular store pointers
   // ----------------------------------------
   // Reads wait for an empty output stage, so the spare slot stays free for a stop or single move
   wire logic rd_fire = ce_i && running_ff && !approach_ff && !empty && !rd_pend_ff &&
                        !exec_valid_o && buf_in_ready && !is_open_clr && !is_stop;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ptr_ff <= '0;
      end else if (is_open_clr) begin
         wr_ptr_ff <= '0; // [R1]
      end else if (push_ok) begin
         wr_ptr_ff <= wr_ptr_ff + 1'b1; // [R9]
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_ptr_ff <= '0;
      end else if (is_open_clr) begin
         rd_ptr_ff <= '0; // [R1]
      end else if (rd_fire) begin
         rd_ptr_ff <= rd_ptr_ff + 1'b1; // [R11]
      end
   end

   pcb_mem #(
      .AW(AW),
      .DW(PCB_WORD_W)
   ) u_mem (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .wr_en_i(push_ok),
      .wr_addr_i(wr_ptr_ff[AW-1:0]),
      .wr_data_i(req_i.word),
      .rd_en_i(rd_fire),
      .rd_addr_i(rd_ptr_ff[AW-1:0]),
      .rd_data_o(rd_data)
   );

   // One read in flight; the skid buffer always has room for it
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_pend_ff <= 1'b0;
         rd_first_ff <= 1'b0;
      end else if (ce_i) begin
         rd_pend_ff <= rd_fire;
         if (rd_fire) begin
            rd_first_ff <= (rd_ptr_ff == '0); // Entry 0 is the start point [R4]
         end
      end
   end

   // ----------------------------------------
   // Motion sequencing
   // ----------------------------------------
   wire logic start_cmd = cmd_v && req_i.cmd == PCB_CMD_START_BUFFERED_MOTION &&
                          list_ff != PCB_L_IDLE && !running_ff;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         running_ff <= 1'b0;
      end else if (cmd_v) begin
         if (is_open_clr || (is_stop && !approach_ff)) begin
            running_ff <= 1'b0; // [R15]
         end else if (start_cmd) begin
            running_ff <= 1'b1; // [R12] [R14]
         end
      end
   end

   // Set by a stop while running outside an approach, so the next start returns first if entries remain
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         need_approach_ff <= 1'b0;
      end else if (ce_i) begin
         if (is_open_clr) begin
            need_approach_ff <= 1'b0;
         end else if (is_stop && running_ff && !approach_ff) begin
            need_approach_ff <= 1'b1; // [R18]
         end else if (start_cmd) begin
            need_approach_ff <= 1'b0;
         end
      end
   end

   wire logic approach_issue = start_cmd && need_approach_ff && !empty && buf_in_ready;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         approach_ff <= 1'b0;
      end else if (ce_i) begin
         if (is_open_clr) begin
            approach_ff <= 1'b0;
         end else if (approach_issue || (rd_pend_ff && rd_first_ff)) begin
            approach_ff <= 1'b1; // [R4] [R18]
         end else if (motion_done_i) begin
            approach_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         single_busy_ff <= 1'b0;
      end else if (ce_i) begin
         if (single_go && buf_in_ready) begin
            single_busy_ff <= 1'b1; // [R17]
         end else if (motion_done_i) begin
            single_busy_ff <= 1'b0; // [R20]
         end
      end
   end

   // Feed to the engine: stored entry, single segment, approach or smooth stop
   always_comb begin
      buf_in_valid = 1'b0;
      buf_in.kind = PCB_EX_BUFFER;
      buf_in.word = rd_data;
      if (rd_pend_ff) begin
         buf_in_valid = 1'b1; // [R5] Parameter entries ride in order with paths
      end else if (single_go) begin
         buf_in_valid = 1'b1; // [R17]
         buf_in.kind = PCB_EX_SINGLE;
         buf_in.word = req_i.word;
      end else if (approach_issue) begin
         buf_in_valid = 1'b1; // [R18]
         buf_in.kind = PCB_EX_APPROACH;
         buf_in.word = '0;
      end else if (is_stop && !approach_ff && req_i.cmd == PCB_CMD_SMOOTH_STOP_MOTION) begin
         buf_in_valid = 1'b1; // [R15]
         buf_in.kind = PCB_EX_SMOOTH_STOP;
         buf_in.word = '0;
      end
   end

   pcb_skid #(
      .W($bits(pcb_exec_t))
   ) u_skid (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .in_valid_i(buf_in_valid),
      .in_data_i(buf_in),
      .in_ready_o(buf_in_ready),
      .out_valid_o(exec_valid_o),
      .out_data_o(exec_o),
      .out_ready_i(exec_ready_i)
   );

   // ----------------------------------------
   // Status and segment counter
   // ----------------------------------------
   logic err_ff;
   logic closed_ff;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         err_ff <= 1'b0;
         closed_ff <= 1'b0;
      end else if (ce_i) begin
         if (is_stop && approach_ff) begin
            err_ff <= 1'b1; // [R19]
         end else if (is_open_clr) begin
            err_ff <= 1'b0;
         end
         if ((cmd_v && req_i.cmd == PCB_CMD_CLOSE_LIST && is_open) || (is_stop && is_open)) begin
            closed_ff <= 1'b1; // [R21]
         end else if (is_open_clr || (cmd_v && req_i.cmd == PCB_CMD_REOPEN_LIST)) begin
            closed_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_o <= PCB_STS_RESET;
         waiting_o <= 1'b0;
         full_o <= 1'b0;
      end else if (ce_i) begin
         status_o <= '0;
         status_o[PCB_STS_DONE_BIT] <= !running_ff && !single_busy_ff;
         status_o[PCB_STS_CLOSED_BIT] <= closed_ff; // [R21]
         status_o[PCB_STS_ERR_BIT] <= err_ff;
         status_o[PCB_STS_SINGLE_BIT] <= !is_open && !running_ff;
         waiting_o <= is_open && empty; // [R23]
         full_o <= full; // [R10]
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         seg_num_o <= '0;
      end else if (ce_i) begin
         if (is_open_clr) begin
            seg_num_o <= '0; // [R22]
         end else if (running_ff && motion_done_i && !approach_ff && !empty) begin
            seg_num_o <= seg_num_o + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_clear_empties: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      is_open_clr |=> empty && is_open && seg_num_o == '0) // [R1]
      else $error("open-clear did not empty the store");
   a_close_when_open: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (cmd_v && req_i.cmd == PCB_CMD_CLOSE_LIST && !is_open) |=> res_code_o == PCB_RES_WRONG) // [R6]
      else $error("close accepted while not open");
   a_reopen_opens: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (cmd_v && req_i.cmd == PCB_CMD_REOPEN_LIST && list_ff == PCB_L_CLOSED) |=> is_open) // [R7]
      else $error("reopen did not open");
   a_full_refuses: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (cmd_v && is_push_cmd && is_open && full) |=> res_code_o == PCB_RES_FULL && $stable(wr_ptr_ff)) // [R10]
      else $error("push accepted while full");
   a_read_frees: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rd_fire |=> rd_ptr_ff == $past(rd_ptr_ff) + 1'b1 && rd_pend_ff) // [R11]
      else $error("read did not free an entry");
   a_stop_closes: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (is_stop && is_open) |=> list_ff == PCB_L_CLOSED ##1 status_o[PCB_STS_CLOSED_BIT]) // [R16]
      else $error("stop did not close the list");
   a_approach_err: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (is_stop && approach_ff) |=> ##1 status_o[PCB_STS_ERR_BIT]) // [R19]
      else $error("stop during approach not flagged");
   a_single_busy: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (cmd_v && req_i.cmd == PCB_CMD_PATH && !is_open && single_busy_ff) |=> res_code_o == PCB_RES_WRONG) // [R20]
      else $error("path accepted during single move");
   a_single_exec: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (single_go && buf_in_ready && !rd_pend_ff) |=> exec_valid_o ##0 single_busy_ff) // [R17]
      else $error("single segment not issued");
   a_waiting_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (ce_i && is_open && empty) |=> waiting_o) // [R23]
      else $error("waiting flag missing");
   c_full: cover property (@(posedge clk_i) disable iff (!rst_b_i) full);
   c_stop_running: cover property (@(posedge clk_i) disable iff (!rst_b_i) is_stop && running_ff);
   c_approach: cover property (@(posedge clk_i) disable iff (!rst_b_i) approach_issue);
   c_wrap: cover property (@(posedge clk_i) disable iff (!rst_b_i) rd_fire && rd_ptr_ff[AW]);
endmodule

// Two-entry skid buffer between the sequencer and the motion engine
module pcb_skid #(
   parameter int unsigned W = 8
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   logic [W-1:0] spare_ff;
   logic spare_v_ff;
   wire logic pop = out_valid_o && out_ready_i;
   wire logic push = in_valid_i && in_ready_o;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
         spare_v_ff <= 1'b0;
         spare_ff <= '0;
         in_ready_o <= 1'b1;
      end else if (ce_i) begin
         if (!out_valid_o || pop) begin
            out_valid_o <= spare_v_ff || push;
            out_data_o <= spare_v_ff ? spare_ff : in_data_i;
            spare_v_ff <= spare_v_ff && push;
            if (spare_v_ff) begin
               spare_ff <= in_data_i;
            end
            in_ready_o <= 1'b1;
         end else if (push) begin
            spare_v_ff <= 1'b1;
            spare_ff <= in_data_i;
            in_ready_o <= 1'b0;
         end
      end
   end
endmodule

/* sim/pcb_engine_model.sv */
// Behavioural motion engine that takes moves from the sequencer and reports their end
`timescale 1ns/100ps
module pcb_engine_model
   import pcb_pkg::*;
#(
   parameter int unsigned LAT = 4
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic exec_valid_i,
   input wire pcb_exec_t exec_i,
   input wire logic stall_i,
   output logic exec_ready_o,
   output logic motion_done_o
);
   logic busy_ff;
   logic [7:0] cnt_ff;
   // A stall freezes the running move too, so a stop can land while it is in flight
   assign exec_ready_o = !stall_i && !busy_ff;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_ff <= 1'b0;
         cnt_ff <= 8'h00;
         motion_done_o <= 1'b0;
      end else begin
         motion_done_o <= 1'b0;
         if (exec_valid_i && exec_ready_o && exec_i.kind != PCB_EX_SMOOTH_STOP) begin
            busy_ff <= 1'b1;
            cnt_ff <= 8'(LAT);
         end else if (busy_ff && !stall_i) begin
            cnt_ff <= cnt_ff - 8'h01;
            if (cnt_ff == 8'h01) begin
               busy_ff <= 1'b0;
               motion_done_o <= 1'b1;
            end
         end
      end
   end
endmodule

/* sim/pcb_sequencer_tb.sv */
// Self-checking testbench for the path command buffer sequencer
`timescale 1ns/100ps
module pcb_sequencer_tb
   import pcb_pkg::*;
;
   logic clk_i = 1'b0, rst_b_i = 1'b0, req_valid_i = 1'b0, stall = 1'b1;
   pcb_req_t req_i = '0;
   logic res_valid_o, exec_valid_o, exec_ready, motion_done, waiting_o, full_o;
   logic [1:0] res_code_o;
   logic [7:0] status_o;
   logic [15:0] seg_num_o;
   pcb_exec_t exec_o;
   pcb_exec_t q[$];
   int mismatches = 0, compares = 0, cyc = 0;

   always #4 clk_i = ~clk_i;

   pcb_sequencer uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .req_valid_i(req_valid_i),
      .req_i(req_i), .res_valid_o(res_valid_o), .res_code_o(res_code_o), .exec_valid_o(exec_valid_o),
      .exec_o(exec_o), .exec_ready_i(exec_ready), .motion_done_i(motion_done), .status_o(status_o),
      .seg_num_o(seg_num_o), .waiting_o(waiting_o), .full_o(full_o));
   pcb_engine_model #(.LAT(4)) eng (.clk_i(clk_i), .rst_b_i(rst_b_i), .exec_valid_i(exec_valid_o),
      .exec_i(exec_o), .stall_i(stall), .exec_ready_o(exec_ready), .motion_done_o(motion_done));

   // Looked at mid-cycle, where the handshake for the next edge has settled
   always @(negedge clk_i) begin
      if (rst_b_i && exec_valid_o === 1'b1 && exec_ready === 1'b1) q.push_back(exec_o);
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic cmd(pcb_cmd_t c, logic [15:0] w, logic [1:0] e);
      int n;
      n = 0;
      req_valid_i = 1'b1;
      req_i = '{cmd: c, word: w};
      @(posedge clk_i);
      #1 req_valid_i = 1'b0;
      while (res_valid_o !== 1'b1 && n < 4) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk("res_valid", 16'h0001, {15'h0000, res_valid_o});
      chk("res_code", {14'h0000, e}, {14'h0000, res_code_o});
      // One idle cycle keeps valid low between back-to-back commands
      idle(1);
   endtask
   // Pops the next move handed to the engine; an empty queue yields all ones, kind smooth stop and word FFFF
   task automatic exp_exec(pcb_exec_kind_t k, logic [15:0] w);
      int n;
      pcb_exec_t x;
      n = 0;
      while (q.size() == 0 && n < 200) begin
         @(posedge clk_i);
         #1 n++;
      end
      x = (q.size() != 0) ? q.pop_front() : '1;
      chk("exec_kind", {14'h0000, k}, {14'h0000, x.kind});
      chk("exec_word", w, x.word);
   endtask
   task automatic wait_kind(pcb_exec_kind_t k);
      int n;
      logic hit;
      pcb_exec_t x;
      n = 0;
      hit = 1'b0;
      while (!hit && n < 300) begin
         if (q.size() != 0) begin
            x = q.pop_front();
            hit = (x.kind == k);
         end else begin
            @(posedge clk_i);
            #1 n++;
         end
      end
      chk("exec_seen", 16'h0001, {15'h0000, hit});
   endtask
   task automatic stop_test();
      $display("Compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_refuse();
      chk("status", 16'h0081, {8'h00, status_o});
      chk("seg_num", 16'h0000, seg_num_o);
      cmd(PCB_CMD_PATH, 16'h0001, PCB_RES_OK);
      stall = 1'b0;
      exp_exec(PCB_EX_SINGLE, 16'h0001);
      idle(10);
      stall = 1'b1;
      cmd(PCB_CMD_CLOSE_LIST, 16'h0000, PCB_RES_WRONG);
      cmd(PCB_CMD_REOPEN_LIST, 16'h0000, PCB_RES_WRONG);
      cmd(PCB_CMD_START_BUFFERED_MOTION, 16'h0000, PCB_RES_WRONG);
   endtask
   task automatic t_list();
      cmd(PCB_CMD_OPEN_CLEAR_LIST, 16'h0000, PCB_RES_OK);
      chk("waiting", 16'h0001, {15'h0000, waiting_o});
      cmd(PCB_CMD_START_POINT, 16'h1000, PCB_RES_OK);
      cmd(PCB_CMD_PATH, 16'h1001, PCB_RES_OK);
      cmd(PCB_CMD_PARAM, 16'h1002, PCB_RES_OK);
      cmd(PCB_CMD_CLOSE_LIST, 16'h0000, PCB_RES_OK);
      chk("closed", 16'h0001, {15'h0000, status_o[PCB_STS_CLOSED_BIT]});
      cmd(PCB_CMD_CLOSE_LIST, 16'h0000, PCB_RES_WRONG);
      cmd(PCB_CMD_REOPEN_LIST, 16'h0000, PCB_RES_OK);
      cmd(PCB_CMD_PATH, 16'h1003, PCB_RES_OK);
      cmd(PCB_CMD_CLOSE_LIST, 16'h0000, PCB_RES_OK);
      cmd(PCB_CMD_REOPEN_LIST, 16'h0000, PCB_RES_OK);
      cmd(PCB_CMD_CLOSE_LIST, 16'h0000, PCB_RES_OK);
      cmd(PCB_CMD_START_BUFFERED_MOTION, 16'h0000, PCB_RES_OK);
      stall = 1'b0;
      exp_exec(PCB_EX_BUFFER, 16'h1000);
      for (int i = 1; i < 4; i++) exp_exec(PCB_EX_BUFFER, 16'h1000 + 16'(i));
      idle(30);
   endtask
   task automatic t_live();
      cmd(PCB_CMD_OPEN_CLEAR_LIST, 16'h0000, PCB_RES_OK);
      cmd(PCB_CMD_START_POINT, 16'h2000, PCB_RES_OK);
      chk("waiting", 16'h0000, {15'h0000, waiting_o});
      cmd(PCB_CMD_START_BUFFERED_MOTION, 16'h0000, PCB_RES_OK);
      exp_exec(PCB_EX_BUFFER, 16'h2000);
      cmd(PCB_CMD_PATH, 16'h2001, PCB_RES_OK);
      exp_exec(PCB_EX_BUFFER, 16'h2001);
      stall = 1'b1;
      for (int i = 2; i < 8; i++) cmd(PCB_CMD_PATH, 16'h2000 + 16'(i), PCB_RES_OK);
      cmd(PCB_CMD_SMOOTH_STOP_MOTION, 16'h0000, PCB_RES_OK);
      chk("closed", 16'h0001, {15'h0000, status_o[PCB_STS_CLOSED_BIT]});
      stall = 1'b0;
      wait_kind(PCB_EX_SMOOTH_STOP);
      idle(20);
      cmd(PCB_CMD_PATH, 16'h2100, PCB_RES_OK);
      cmd(PCB_CMD_PATH, 16'h2101, PCB_RES_WRONG);
      exp_exec(PCB_EX_SINGLE, 16'h2100);
      idle(20);
      stall = 1'b1;
      cmd(PCB_CMD_START_BUFFERED_MOTION, 16'h0000, PCB_RES_OK);
      cmd(PCB_CMD_ABRUPT_STOP_MOTION, 16'h0000, PCB_RES_WRONG);
      chk("motion_err", 16'h0001, {15'h0000, status_o[PCB_STS_ERR_BIT]});
      stall = 1'b0;
      wait_kind(PCB_EX_APPROACH);
      idle(60);
   endtask
   task automatic t_full();
      stall = 1'b1;
      cmd(PCB_CMD_OPEN_CLEAR_LIST, 16'h0000, PCB_RES_OK);
      chk("seg_num", 16'h0000, seg_num_o);
      q.delete();
      for (int i = 0; i < 4096; i++) cmd(i == 0 ? PCB_CMD_START_POINT : PCB_CMD_PATH, 16'h3000 + 16'(i), PCB_RES_OK);
      chk("full", 16'h0001, {15'h0000, full_o});
      cmd(PCB_CMD_PARAM, 16'h4000, PCB_RES_FULL);
      cmd(PCB_CMD_PATH, 16'h4001, PCB_RES_FULL);
      cmd(PCB_CMD_START_BUFFERED_MOTION, 16'h0000, PCB_RES_OK);
      stall = 1'b0;
      exp_exec(PCB_EX_BUFFER, 16'h3000);
      exp_exec(PCB_EX_BUFFER, 16'h3001);
      idle(20);
      chk("full", 16'h0000, {15'h0000, full_o});
      cmd(PCB_CMD_PATH, 16'h4002, PCB_RES_OK);
      cmd(PCB_CMD_OPEN_CLEAR_LIST, 16'h0000, PCB_RES_OK);
      chk("waiting", 16'h0001, {15'h0000, waiting_o});
      chk("full", 16'h0000, {15'h0000, full_o});
   endtask

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      repeat (16) @(posedge clk_i);
      #1 rst_b_i = 1'b1;
      t_refuse();
      t_list();
      t_live();
      t_full();
      stop_test();
   end
endmodule
